// ### common/wwdt_pkg.sv
package wwdt_pkg;

    // ==========================================================
    // register map
    localparam logic [3:0] WWDT_OFS_CMD = 4'h0;
    localparam logic [3:0] WWDT_OFS_SETUP = 4'h4;
    localparam logic [3:0] WWDT_OFS_STATUS = 4'h8;

    // ==========================================================
    // field layout and values
    localparam logic [31:0] WWDT_SETUP_RESET = 32'h3FFF2FFF;
    localparam logic [7:0] WWDT_UNLOCK_VALUE = 8'hA5;
    localparam int WWDT_CNT_W = 12;
    localparam int WWDT_PRESCALE = 128;
    localparam int WWDT_SLOW_HZ = 32768;
    localparam int WWDT_CLK_HZ = 100000000;
    localparam int WWDT_MOD_W = 27; // holds the fast clock rate in full

    // ==========================================================
    // setup register fields
    typedef struct packed {
        logic [1:0] unused;
        logic idle_freeze;
        logic debug_freeze;
        logic [11:0] window_limit;
        logic timer_off;
        logic core_only_reset_select;
        logic fault_reset_enable;
        logic fault_irq_enable;
        logic [11:0] reload_count;
    } wwdt_setup_t;

    // fault request toward the reset controller
    typedef struct packed {
        logic fault;
        logic core_only;
    } wwdt_fault_t;

endpackage : wwdt_pkg

// ### src/wwdt_core.sv
`timescale 1ns/1ps

// Overview of operation
// - 12-bit down counter loads reload count on every restart except an early kick.
// - counter decrements once per slow clock divided by 128 tick.
// - after reset reload is 0xFFF, running, fault reset enabled.
// - setup register takes only its first write after reset.
// - a setup write reloads the counter and restarts counting.
// - accepted restart reloads counter and resets the prescaler.
// - command restart only with kick bit set and key byte 0xA5.
// - underflow sets flag; fault output only if fault reset enabled.
// - restart above window limit sets error flag and fault, even disabled.
// - window limit at or above reload never gives an error.
// - interrupt when a flag is set and interrupt enable is set.
// - watchdog reset clears processor, watchdog and both flags.
// - status read or reset clears flags, interrupt and fault.
// - counting stops in debug or idle when the freeze bit is set.
// - fault requests full system or processor-only reset.
// - core-only select 1 gives processor reset, 0 all resets.
// - timer-off 1 disables the timer, 0 enables it.
// - setup register field positions as declared in the package.
module wwdt_core
    import wwdt_pkg::*;
#(
    parameter int CNT_W = WWDT_CNT_W,
    parameter int PRESCALE = WWDT_PRESCALE
)
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic DEBUG_STATE,
    input wire logic IDLE_STATE,
    output logic [31:0] RDATA,
    output logic IRQ,
    output wwdt_fault_t FAULT,
    output logic [CNT_W-1:0] COUNT
);
    // ==========================================================
    // state
    wwdt_setup_t setup_q;
    logic locked_q;
    logic [CNT_W-1:0] cnt_q;
    logic unf_q;
    logic err_q;
    logic tick;
    logic kick;
    logic setup_wr;
    logic restart;
    logic frozen;
    logic run;
    logic underflow;
    logic early;
    logic st_rd;

    // ==========================================================
    // decode
    assign kick = WR && ADDR == WWDT_OFS_CMD && WDATA[0]
        && WDATA[31:24] == WWDT_UNLOCK_VALUE;
    assign setup_wr = WR && ADDR == WWDT_OFS_SETUP && !locked_q;
    assign st_rd = RD && ADDR == WWDT_OFS_STATUS;
    assign early = kick && cnt_q > CNT_W'(setup_q.window_limit)
        && setup_q.window_limit < setup_q.reload_count;
    assign restart = kick || setup_wr;
    assign frozen = (DEBUG_STATE && setup_q.debug_freeze)
        || (IDLE_STATE && setup_q.idle_freeze);
    assign run = !setup_q.timer_off && !frozen;
    assign underflow = tick && run && cnt_q == '0;

    // prescaler
    wwdt_tick_gen #(
        .DIV(PRESCALE)
    ) u_tick (
        .clk(CLOCK),
        .rst(RST),
        .restart(restart),
        .run(run),
        .tick(tick)
    );

    // write-once setup register
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            setup_q <= WWDT_SETUP_RESET;
            locked_q <= 1'b0;
        end
        else if (setup_wr)
        begin
            setup_q <= WDATA;
            locked_q <= 1'b1;
        end
    end

    // down counter
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            cnt_q <= CNT_W'(WWDT_SETUP_RESET[11:0]);
        else if (setup_wr)
            cnt_q <= CNT_W'(WDATA[11:0]);
        else if (kick && !early)
            cnt_q <= CNT_W'(setup_q.reload_count);
        else if (tick && run && cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
    end

    // sticky flags, set wins over read clear
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            unf_q <= 1'b0;
            err_q <= 1'b0;
        end
        else
        begin
            unf_q <= underflow || (unf_q && !st_rd);
            err_q <= early || (err_q && !st_rd);
        end
    end

    // fault request toward the reset controller, set wins over read
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            FAULT <= '0;
        else
        begin
            if (early)
                FAULT.fault <= 1'b1;
            else if (underflow && setup_q.fault_reset_enable)
                FAULT.fault <= 1'b1;
            else if (st_rd)
                FAULT.fault <= 1'b0;
            FAULT.core_only <=
                setup_q.core_only_reset_select;
        end
    end

    // interrupt level, follows the flags while enabled
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            IRQ <= 1'b0;
        else
            IRQ <= setup_q.fault_irq_enable
                && (underflow || early
                    || ((unf_q || err_q) && !st_rd));
    end

    // read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            RDATA <= '0;
        else if (RD && ADDR == WWDT_OFS_SETUP)
            RDATA <= setup_q;
        else if (st_rd)
            RDATA <= {30'h0, err_q, unf_q};
        else
            RDATA <= '0;
    end

    // counter copy for observation, one cycle late
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            COUNT <= '0;
        else
            COUNT <= cnt_q;
    end

    // ==========================================================
    // checks

    // cycles since the last tick or restart, saturating
    localparam int GAP_W = 20;
    localparam int SLOW_CYC = WWDT_CLK_HZ / WWDT_SLOW_HZ;
    localparam logic [GAP_W-1:0] GAP_MIN =
        GAP_W'((PRESCALE - 1) * SLOW_CYC);
    logic [GAP_W-1:0] gap_q;

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            gap_q <= '0;
        else if (tick || restart)
            gap_q <= '0;
        else if (gap_q != '1)
            gap_q <= gap_q + 1'b1;
    end

    a_key_guard: assert property (
        @(posedge CLOCK) disable iff (RST)
        WR && ADDR == WWDT_OFS_CMD && WDATA[31:24] != WWDT_UNLOCK_VALUE
        && !tick |=> cnt_q == $past(cnt_q))
        else $error("bad key changed counter");

    a_write_once: assert property (
        @(posedge CLOCK) disable iff (RST)
        locked_q |=> setup_q == $past(setup_q))
        else $error("setup changed after lock");

    a_early_err: assert property (
        @(posedge CLOCK) disable iff (RST)
        early |=> err_q && FAULT.fault)
        else $error("early kick not flagged");

    a_unf_flag: assert property (
        @(posedge CLOCK) disable iff (RST)
        underflow |=> unf_q)
        else $error("underflow not flagged");

    a_rd_clear: assert property (
        @(posedge CLOCK) disable iff (RST)
        st_rd && !underflow && !early |=> !unf_q && !err_q && !FAULT.fault)
        else $error("status read did not clear");

    a_kick_load: assert property (
        @(posedge CLOCK) disable iff (RST)
        kick && !early && !setup_wr |=> cnt_q == setup_q.reload_count)
        else $error("kick did not reload");

    a_freeze_hold: assert property (
        @(posedge CLOCK) disable iff (RST)
        !run && !restart |=> cnt_q == $past(cnt_q))
        else $error("counter moved while stopped");

    a_irq_gate: assert property (
        @(posedge CLOCK) disable iff (RST)
        IRQ |-> $past(setup_q.fault_irq_enable))
        else $error("interrupt without enable");

    a_tick_step: assert property (
        @(posedge CLOCK) disable iff (RST)
        tick && run && cnt_q != '0 && !restart
        |=> cnt_q == $past(cnt_q) - 1'b1)
        else $error("tick did not decrement");

    a_tick_gap: assert property (
        @(posedge CLOCK) disable iff (RST)
        tick |-> gap_q >= GAP_MIN)
        else $error("prescaler tick came too soon");

    a_setup_load: assert property (
        @(posedge CLOCK) disable iff (RST)
        setup_wr |=> cnt_q == $past(WDATA[11:0]) && locked_q)
        else $error("setup write did not reload");

    a_pre_clear: assert property (
        @(posedge CLOCK) disable iff (RST)
        restart |=> !tick)
        else $error("prescaler not restarted");

    a_unf_fault: assert property (
        @(posedge CLOCK) disable iff (RST)
        underflow && setup_q.fault_reset_enable |=> FAULT.fault)
        else $error("underflow fault missing");

    a_err_hold: assert property (
        @(posedge CLOCK) disable iff (RST)
        early && !tick |=> cnt_q == $past(cnt_q))
        else $error("early kick changed counter");

    a_core_sel: assert property (
        @(posedge CLOCK) disable iff (RST)
        FAULT.core_only == $past(setup_q.core_only_reset_select))
        else $error("reset kind does not follow setup");

    a_off_hold: assert property (
        @(posedge CLOCK) disable iff (RST)
        setup_q.timer_off && !restart |=> cnt_q == $past(cnt_q))
        else $error("counter moved while off");

    a_irq_level: assert property (
        @(posedge CLOCK) disable iff (RST)
        IRQ == ($past(setup_q.fault_irq_enable) && (unf_q || err_q)))
        else $error("interrupt does not follow flags");

    a_fault_hold: assert property (
        @(posedge CLOCK) disable iff (RST)
        FAULT.fault && !st_rd |=> FAULT.fault)
        else $error("fault dropped without read");

    c_kick: cover property (@(posedge CLOCK) kick && !early);
    c_early: cover property (@(posedge CLOCK) early);
    c_unf: cover property (@(posedge CLOCK) underflow);
    c_lock: cover property (@(posedge CLOCK) setup_wr);
    c_full: cover property (@(posedge CLOCK) FAULT.fault && !FAULT.core_only);

endmodule : wwdt_core

// ### src/wwdt_tick_gen.sv
`timescale 1ns/1ps

// ==========================================================
// slow clock emulation and divide-by-128 prescaler
module wwdt_tick_gen
    import wwdt_pkg::*;
#(
    parameter int DIV = WWDT_PRESCALE
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic run,
    output logic tick
);
    localparam logic [WWDT_MOD_W-1:0] SLOW_HZ_W =
        WWDT_MOD_W'(WWDT_SLOW_HZ);
    localparam logic [WWDT_MOD_W-1:0] CLK_HZ_W = WWDT_MOD_W'(WWDT_CLK_HZ);
    localparam logic [7:0] DIV_LAST = 8'(DIV - 1);

    logic [WWDT_MOD_W-1:0] acc_q;
    logic slow_edge;
    logic [7:0] div_q;

    // fractional accumulator makes slow clock edges from the fast clock
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            acc_q <= '0;
        else if (acc_q + SLOW_HZ_W >= CLK_HZ_W)
            acc_q <= acc_q + SLOW_HZ_W - CLK_HZ_W;
        else
            acc_q <= acc_q + SLOW_HZ_W;
    end

    assign slow_edge = (acc_q + SLOW_HZ_W >= CLK_HZ_W);

    // prescaler, reset on restart
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_q <= '0;
            tick <= 1'b0;
        end
        else if (restart)
        begin
            div_q <= '0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= 1'b0;
            if (run && slow_edge)
            begin
                if (div_q == DIV_LAST)
                begin
                    div_q <= '0;
                    tick <= 1'b1;
                end
                else
                    div_q <= div_q + 8'h01;
            end
        end
    end

endmodule : wwdt_tick_gen

// ### testbench/tb.sv
`timescale 1ns/1ps

// ==========================================================
// bench for the windowed watchdog
module tb;
    import wwdt_pkg::*;
    localparam logic [31:0] KICK = 32'hA5000001;
    localparam logic [31:0] SETUP_A = 32'h00105100;
    localparam int SLOW3 = 3 * WWDT_CLK_HZ / WWDT_SLOW_HZ + 100;
    localparam logic [31:0] SETUP_B = 32'h1FFF3001;
    localparam logic [31:0] SETUP_C = 32'h00108100;
    localparam int SPAN = 7000;
    localparam int LIMIT = 60000;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic dbg = 1'b0;
    logic idle = 1'b0;
    logic [31:0] rdata;
    logic irq;
    wwdt_fault_t fault;
    logic [11:0] count;
    logic [31:0] d;
    int core_req;
    int full_req;
    int fails = 0;
    int cmp_count = 0;

    // ==========================================================
    // clock, design and reset controller model
    always #5 clock = ~clock;

    // prescaler shortened so that ticks fit in the run
    wwdt_core #(.PRESCALE(2)) u_wwdt_core (.CLOCK(clock), .RST(rst),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .DEBUG_STATE(dbg),
        .IDLE_STATE(idle), .RDATA(rdata), .IRQ(irq), .FAULT(fault),
        .COUNT(count));

    wwdt_rstc_model u_wwdt_rstc_model (.clk(clock), .fault(fault),
        .core_req(core_req), .full_req(full_req));

    // ==========================================================
    // compare and bus tasks
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_bit

    task bus_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : bus_wr

    task bus_rd(input logic [3:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : bus_rd

    task settle;
        repeat (2) @(posedge clock);
        #1;
    endtask : settle

    // ==========================================================
    // scenarios
    task t_reset_values;
        settle;
        chk_word({20'h0, count}, 32'h00000FFF);
        bus_rd(WWDT_OFS_SETUP);
        chk_word(d, WWDT_SETUP_RESET);
        bus_rd(WWDT_OFS_STATUS);
        chk_word(d, 32'h0);
        bus_rd(4'hC);
        chk_word(d, 32'h0);
        $display("test reset_values done");
    endtask : t_reset_values

    task t_default_kick;
        bus_wr(WWDT_OFS_CMD, 32'h5A000001);
        bus_wr(WWDT_OFS_CMD, KICK);
        settle;
        chk_bit(fault.fault, 1'b0);
        bus_rd(WWDT_OFS_STATUS);
        chk_word(d, 32'h0);
        $display("test default_kick done");
    endtask : t_default_kick

    task t_setup_once;
        bus_wr(WWDT_OFS_SETUP, SETUP_A);
        settle;
        chk_word({20'h0, count}, 32'h00000100);
        bus_rd(WWDT_OFS_SETUP);
        chk_word(d, SETUP_A);
        bus_wr(WWDT_OFS_SETUP, 32'h0FFF0FFF);
        bus_rd(WWDT_OFS_SETUP);
        chk_word(d, SETUP_A);
        $display("test setup_once done");
    endtask : t_setup_once

    task t_early_kick;
        bus_wr(WWDT_OFS_CMD, 32'h5A000001);
        bus_wr(WWDT_OFS_CMD, 32'hA5000000);
        settle;
        chk_bit(fault.fault, 1'b0);
        bus_wr(WWDT_OFS_CMD, KICK);
        settle;
        chk_bit(fault.fault, 1'b1);
        chk_bit(fault.core_only, 1'b1);
        chk_bit(irq, 1'b1);
        chk_word({20'h0, count}, 32'h00000100);
        bus_rd(WWDT_OFS_STATUS);
        chk_word(d, 32'h2);
        settle;
        chk_bit(fault.fault, 1'b0);
        chk_bit(irq, 1'b0);
        bus_rd(WWDT_OFS_STATUS);
        chk_word(d, 32'h0);
        $display("test early_kick done");
    endtask : t_early_kick

    task t_reset_clear;
        bus_wr(WWDT_OFS_CMD, KICK);
        settle;
        chk_bit(fault.fault, 1'b1);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        settle;
        chk_bit(fault.fault, 1'b0);
        chk_bit(irq, 1'b0);
        bus_rd(WWDT_OFS_STATUS);
        chk_word(d, 32'h0);
        bus_rd(WWDT_OFS_SETUP);
        chk_word(d, WWDT_SETUP_RESET);
        chk_word(core_req, 32'h2);
        chk_word(full_req, 32'h0);
        $display("test reset_clear done");
    endtask : t_reset_clear

    // run out from reload 1 after a debug freeze, full reset asked
    task t_underflow;
        int n;
        bus_wr(WWDT_OFS_SETUP, SETUP_B);
        dbg <= 1'b1;
        repeat (SPAN) @(posedge clock);
        #1;
        chk_word({20'h0, count}, 32'h00000001);
        @(posedge clock);
        dbg <= 1'b0;
        n = 0;
        while (count != 12'h000 && n < SPAN)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        chk_word({20'h0, count}, 32'h00000000);
        chk_bit(fault.fault, 1'b0);
        n = 0;
        while (fault.fault !== 1'b1 && n < SPAN)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        chk_bit(fault.fault, 1'b1);
        chk_bit(fault.core_only, 1'b0);
        chk_bit(irq, 1'b1);
        chk_word({20'h0, count}, 32'h00000000);
        bus_rd(WWDT_OFS_STATUS);
        chk_word(d, 32'h1);
        chk_word(full_req, 32'h1);
        $display("test underflow done");
    endtask : t_underflow

    // second reset; a stopped timer still flags an early kick
    task t_timer_off;
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        bus_wr(WWDT_OFS_SETUP, SETUP_C);
        repeat (SPAN) @(posedge clock);
        #1;
        chk_word({20'h0, count}, 32'h00000100);
        bus_wr(WWDT_OFS_CMD, KICK);
        settle;
        chk_bit(fault.fault, 1'b1);
        chk_bit(irq, 1'b0);
        bus_rd(WWDT_OFS_STATUS);
        chk_word(d, 32'h2);
        chk_word(full_req, 32'h2);
        $display("test timer_off done");
    endtask : t_timer_off

    task print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    // ==========================================================
    // main sequence; setup write held off after a kick
    initial
    begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        t_reset_values;
        t_default_kick;
        repeat (SLOW3) @(posedge clock);
        t_setup_once;
        t_early_kick;
        t_reset_clear;
        t_underflow;
        t_timer_off;
        print_verdict;
    end

    // watchdog on the bench itself
    initial
    begin
        repeat (LIMIT) @(posedge clock);
        fails++;
        print_verdict;
    end
endmodule : tb

// ### testbench/wwdt_rstc_model.sv
`timescale 1ns/1ps

// ==========================================================
// reset controller stand-in: counts fault requests by kind
module wwdt_rstc_model
    import wwdt_pkg::*;
(
    input wire logic clk,
    input wire wwdt_fault_t fault,
    output int core_req,
    output int full_req
);
    logic last_q = 1'b0;

    // one request per rising fault level, split by reset kind
    always_ff @(posedge clk)
    begin
        last_q <= fault.fault;
        if (fault.fault && !last_q)
        begin
            if (fault.core_only)
                core_req <= core_req + 1;
            else
                full_req <= full_req + 1;
        end
    end
endmodule : wwdt_rstc_model
